/* bench/general_purpose_port_zero_props.sv */
`timescale 1ns/1ps
// ----
// Bus and pad checks
// ----
module port_zero_props #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic             sys_clk,
    input wire logic             resetn,
    // APB
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic [3:0]       pstrb,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    // Pins
    input wire logic [WIDTH-1:0] pin_out,
    input wire logic [WIDTH-1:0] pin_oe_n,
    input wire logic [WIDTH-1:0] pin_pullup_en
);
    // Setup phase, and writes at the completing access edge
    wire setup = psel && !penable;
    wire wr_ok = psel && penable && pready && pwrite && pstrb[0];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    chk_rst_pins: assert property (disable iff (1'h0) !resetn |=> &pin_oe_n)
        else $error("pins driven after reset");
    chk_ready_next: assert property (setup |=> pready) else $error("late ready");
    chk_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
    chk_err_unmap: assert property (setup && paddr >= 12'h01C |=> pslverr)
        else $error("unmapped not refused");
    chk_err_pair: assert property (pslverr |-> pready) else $error("lone error");
    chk_upper_zero: assert property (pready |-> prdata[31:8] == '0)
        else $error("upper read bits set");
    chk_latch_pin: assert property (wr_ok && paddr == 12'h000 |=> ##1
        pin_out == $past(pwdata[WIDTH-1:0], 2)) else $error("latch not on pins");
    chk_dir_pin: assert property (wr_ok && paddr == 12'h004 |=> ##1
        pin_oe_n == ~$past(pwdata[WIDTH-1:0], 2)) else $error("direction not on pins");
    chk_pull_low: assert property ((pin_pullup_en & ~pin_oe_n & ~pin_out) == '0)
        else $error("pull-up on low pin");
    // Main scenarios
    cover property (wr_ok && paddr == 12'h000);
    cover property (pslverr);
    cover property (pin_oe_n == '0);
endmodule // port_zero_props

/* bench/general_purpose_port_zero_test.sv */
`timescale 1ns/1ps
// ----
// Port zero bench
// ----
module general_purpose_port_zero_test;
    typedef struct packed {
        logic w; logic [11:0] a; logic [7:0] d; logic s; logic [7:0] e; logic x;
    } row_t;
    logic        sys_clk = 1'h0;
    logic        resetn = 1'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hF;
    logic [7:0]  ext_val = 8'h3C;
    logic [7:0]  ext_en = 8'hFF;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, er;
    logic [7:0]  pin_level;
    int          fails = 0;
    int          total_checks = 0;
    wire gpio_port_pkg::pad_drive_t pad;
    // Register accesses, reads carry the expected byte
    row_t rows [17] = '{
        '{1'h0, 12'h000, 8'h00, 1'h1, 8'h00, 1'h0}, '{1'h0, 12'h004, 8'h00, 1'h1, 8'h00, 1'h0},
        '{1'h0, 12'h008, 8'h00, 1'h1, 8'h00, 1'h0}, '{1'h0, 12'h00C, 8'h00, 1'h1, 8'h00, 1'h0},
        '{1'h1, 12'h00C, 8'hFF, 1'h1, 8'h00, 1'h0}, '{1'h0, 12'h000, 8'h00, 1'h1, 8'h3C, 1'h0},
        '{1'h1, 12'h000, 8'hA5, 1'h1, 8'h00, 1'h0}, '{1'h0, 12'h010, 8'h00, 1'h1, 8'hA5, 1'h0},
        '{1'h1, 12'h000, 8'hFF, 1'h0, 8'h00, 1'h0}, '{1'h0, 12'h010, 8'h00, 1'h1, 8'hA5, 1'h0},
        '{1'h1, 12'h004, 8'h0F, 1'h1, 8'h00, 1'h0}, '{1'h0, 12'h000, 8'h00, 1'h1, 8'h35, 1'h0},
        '{1'h1, 12'h008, 8'hF0, 1'h1, 8'h00, 1'h0}, '{1'h0, 12'h008, 8'h00, 1'h1, 8'hF0, 1'h0},
        '{1'h1, 12'h00C, 8'h0F, 1'h1, 8'h00, 1'h0}, '{1'h0, 12'h000, 8'h00, 1'h1, 8'h05, 1'h0},
        '{1'h1, 12'h01C, 8'h77, 1'h1, 8'h00, 1'h1}};
    always #20 sys_clk = ~sys_clk;
    general_purpose_port_zero #(.WIDTH(8)) dut (.sys_clk, .resetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .pin_in(pin_level),
        .pin_out(pad.out_val), .pin_oe_n(pad.out_en_n), .pin_pullup_en(pad.pullup_en));
    pin_world far (.pin_out(pad.out_val), .pin_oe_n(pad.out_en_n),
        .pin_pullup_en(pad.pullup_en), .ext_val, .ext_en, .pin_level);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // One APB transfer, held until ready is sampled
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic s);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= {3'h7, s};
        @(posedge sys_clk);
        penable <= 1'h1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            fails++;
            close_out();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // Table, then pins, float and a second reset
    initial begin
        repeat (6) @(posedge sys_clk);
        resetn <= 1'h1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d, rows[i].s);
            check(er, rows[i].x);
            if (!rows[i].w) begin
                check(rd, {24'h0, rows[i].e});
            end
        end
        check(pad, {8'hA5, 8'hF0, 8'hF0});
        apb(1'h1, 12'h004, 8'hFF, 1'h1);
        apb(1'h1, 12'h000, 8'h3C, 1'h1);
        repeat (2) @(posedge sys_clk);
        check(pad, {8'h3C, 8'h00, 8'h30});
        apb(1'h1, 12'h014, 8'h03, 1'h1);
        repeat (2) @(posedge sys_clk);
        check(pad.out_en_n, 8'hFF);
        apb(1'h1, 12'h004, 8'h00, 1'h1);
        apb(1'h0, 12'h000, 8'h00, 1'h1);
        check(rd, 32'h0);
        apb(1'h1, 12'h018, 8'h04, 1'h1);
        apb(1'h0, 12'h000, 8'h00, 1'h1);
        check(rd, 32'h4);
        apb(1'h1, 12'h014, 8'h00, 1'h1);
        ext_en <= 8'h00;
        apb(1'h1, 12'h00C, 8'hFF, 1'h1);
        apb(1'h0, 12'h000, 8'h00, 1'h1);
        check(rd, 32'hF3);
        resetn <= 1'h0;
        repeat (2) @(posedge sys_clk);
        check(pad, 24'h0_0FF_00);
        resetn <= 1'h1;
        apb(1'h0, 12'h004, 8'h00, 1'h1);
        check(rd, 32'h0);
        apb(1'h0, 12'h000, 8'h00, 1'h1);
        check(rd, 32'h0);
        close_out();
    end
endmodule // general_purpose_port_zero_test

bind general_purpose_port_zero port_zero_props #(.WIDTH(WIDTH)) props (.sys_clk, .resetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .pin_out, .pin_oe_n, .pin_pullup_en);

/* bench/pin_world.sv */
`timescale 1ns/1ps
// ----
// Pad ring with far-side drivers
// ----
module pin_world (
    // Port side
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    input  wire logic [7:0] pin_pullup_en,
    // Far side
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_en,
    output logic      [7:0] pin_level
);
    // pull-up, else toggled so no lucky match
    wire [7:0] idle = pin_pullup_en | ~pin_out;
    wire [7:0] far  = (ext_en & ext_val) | (~ext_en & idle);
    assign pin_level = (~pin_oe_n & pin_out) | (pin_oe_n & far);
endmodule // pin_world

/* verilog/general_purpose_port_zero.sv */
`timescale 1ns/1ps
`include "gpio_port_regs.svh"
// Function
// - Direction one drives latch onto pin
// - Latch write appears on output pins
// - Direction zero leaves pin undriven
// - Input pin latch still written
// - Normal read pin, RMW read latch
// - Output pins read back latch
// - Two read paths for data
// - Config registers read back written value
// - Pull-up select enables pull-up
// - Analog disable one enables digital input
// - Pin n maps to bit n
// - All registers reset to zero
// - Reset makes all pins inputs
// - Standby float blocks pins, and inputs without interrupt enable
// - Pull-up dropped while driving low

module general_purpose_port_zero #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Pins
    input  wire logic [WIDTH-1:0]  pin_in,
    output logic      [WIDTH-1:0]  pin_out,
    output logic      [WIDTH-1:0]  pin_oe_n,
    output logic      [WIDTH-1:0]  pin_pullup_en
);

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    if (WIDTH != 8) begin : g_bad_width
        $error("port width must be 8");
    end

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] latch_ff;
    logic [WIDTH-1:0] dir_ff;
    logic [WIDTH-1:0] pullup_ff;
    logic [WIDTH-1:0] adis_ff;
    logic [WIDTH-1:0] eint_ff;
    logic [2:0]       stby_ff;
    logic [WIDTH-1:0] pin_level;
    gpio_port_pkg::apb_resp_t resp_q_ff;
    gpio_port_pkg::apb_resp_t nxt_resp;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    logic access_w;
    logic wr_w;
    logic lane0_w;
    logic hit_latch_w;
    logic hit_dir_w;
    logic hit_pull_w;
    logic hit_adis_w;
    logic hit_rmw_w;
    logic hit_stby_w;
    logic hit_eint_w;
    logic mapped_w;
    logic float_w;

    // Setup phase only, so each access is taken once
    assign access_w    = psel && !penable;
    assign wr_w        = psel && penable && pwrite && resp_q_ff.pready; // Completing edge
    assign lane0_w     = pstrb[0];
    assign hit_latch_w = (paddr == `OFS_PORT_OUTPUT_LATCH);
    assign hit_dir_w   = (paddr == `OFS_PORT_DIRECTION);
    assign hit_pull_w  = (paddr == `OFS_PORT_PULLUP_SELECT);
    assign hit_adis_w  = (paddr == `OFS_ANALOG_INPUT_DIS_LOW);
    assign hit_rmw_w   = (paddr == `OFS_PORT_LATCH_RMW);
    assign hit_stby_w  = (paddr == `OFS_STANDBY_CONTROL);
    assign hit_eint_w  = (paddr == `OFS_EXT_INT_ENABLE);
    assign mapped_w    = hit_latch_w | hit_dir_w | hit_pull_w | hit_adis_w
                       | hit_rmw_w | hit_stby_w | hit_eint_w;

    // Float only while float bit set and a standby mode entered
    assign float_w = stby_ff[`STBY_FLOAT_BIT]
                   & (stby_ff[`STBY_STOP_BIT] | stby_ff[`STBY_WATCH_BIT]);

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    // Reset clears all, pins become inputs
    // Eight-bit write, three bits for standby, lands on next edge
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            latch_ff  <= `RST_PORT_REG;
            dir_ff    <= `RST_PORT_REG;
            pullup_ff <= `RST_PORT_REG;
            adis_ff   <= `RST_PORT_REG;
            eint_ff   <= `RST_PORT_REG;
            stby_ff   <= 3'h0;
        end else if (wr_w && lane0_w) begin
            if (hit_latch_w || hit_rmw_w) latch_ff <= pwdata[7:0];
            if (hit_dir_w)  dir_ff    <= pwdata[7:0];
            if (hit_pull_w) pullup_ff <= pwdata[7:0];
            if (hit_adis_w) adis_ff   <= pwdata[7:0];
            if (hit_eint_w) eint_ff   <= pwdata[7:0];
            if (hit_stby_w) stby_ff   <= pwdata[2:0];
        end
    end

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    // Inputs read pin level, outputs read latch
    logic [7:0] normal_rd_w;
    assign normal_rd_w = (dir_ff & latch_ff) | (~dir_ff & pin_level);

    // Separate RMW path and plain readback
    always_comb begin
        nxt_resp         = '0;
        nxt_resp.pready  = 1'b1;
        nxt_resp.pslverr = !mapped_w;
        if (!pwrite) begin
            if (hit_latch_w) nxt_resp.prdata[7:0] = normal_rd_w;
            if (hit_rmw_w)   nxt_resp.prdata[7:0] = latch_ff;
            if (hit_dir_w)   nxt_resp.prdata[7:0] = dir_ff;
            if (hit_pull_w)  nxt_resp.prdata[7:0] = pullup_ff;
            if (hit_adis_w)  nxt_resp.prdata[7:0] = adis_ff;
            if (hit_eint_w)  nxt_resp.prdata[7:0] = eint_ff;
            if (hit_stby_w)  nxt_resp.prdata[2:0] = stby_ff;
        end
    end

    // Answer captured at setup, presented in the access phase
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            resp_q_ff <= '0;
        end else begin
            resp_q_ff <= access_w ? nxt_resp : '0;
        end
    end

    // Fields are zero outside the access cycle, so no gating is needed
    assign prdata  = resp_q_ff.prdata;
    assign pready  = resp_q_ff.pready;
    assign pslverr = resp_q_ff.pslverr;

    // ----------------------------------------------------------------
    // Pad control
    // ----------------------------------------------------------------
    port_pad_ctrl #(
        .WIDTH (WIDTH)
    ) u_pad (
        .sys_clk       (sys_clk),
        .resetn        (resetn),
        .latch         (latch_ff),
        .dir           (dir_ff),
        .pull_sel      (pullup_ff),
        .adis          (adis_ff),
        .eint_en       (eint_ff),
        .float_req     (float_w),
        .pin_in        (pin_in),
        .pin_out       (pin_out),
        .pin_oe_n      (pin_oe_n),
        .pin_pullup_en (pin_pullup_en),
        .pin_level     (pin_level)
    );

endmodule // general_purpose_port_zero

/* verilog/gpio_port_pkg.sv */
package gpio_port_pkg;

    // Per-pin drive towards the pad ring
    typedef struct packed {
        logic [7:0] out_val;
        logic [7:0] out_en_n;
        logic [7:0] pullup_en;
    } pad_drive_t;

    // APB slave answer
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_resp_t;

endpackage

/* verilog/gpio_port_regs.svh */
`ifndef GPIO_PORT_REGS_SVH
`define GPIO_PORT_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_PORT_OUTPUT_LATCH      12'h000
`define OFS_PORT_DIRECTION         12'h004
`define OFS_PORT_PULLUP_SELECT     12'h008
`define OFS_ANALOG_INPUT_DIS_LOW   12'h00C
`define OFS_PORT_LATCH_RMW         12'h010
`define OFS_STANDBY_CONTROL        12'h014
`define OFS_EXT_INT_ENABLE         12'h018

// ----------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------
`define RST_PORT_REG               8'h00
`define STBY_FLOAT_BIT             0
`define STBY_STOP_BIT              1
`define STBY_WATCH_BIT             2

`endif

/* verilog/port_pad_ctrl.sv */
`timescale 1ns/1ps
`include "gpio_port_regs.svh"

// Combines register state into registered pad controls and input gating
module port_pad_ctrl #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    // Register state
    input  wire logic [WIDTH-1:0] latch,
    input  wire logic [WIDTH-1:0] dir,
    input  wire logic [WIDTH-1:0] pull_sel,
    input  wire logic [WIDTH-1:0] adis,
    input  wire logic [WIDTH-1:0] eint_en,
    input  wire logic             float_req,
    // Pins
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out,
    output logic      [WIDTH-1:0] pin_oe_n,
    output logic      [WIDTH-1:0] pin_pullup_en,
    output logic      [WIDTH-1:0] pin_level
);

    // ----------------------------------------------------------------
    // Pad decisions
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] drive_w;
    logic [WIDTH-1:0] drive_low_w;
    logic [WIDTH-1:0] in_ok_w;
    // Output drives latch; input not driven
    assign drive_w     = float_req ? '0 : dir;
    assign drive_low_w = drive_w & ~latch;
    // Float forces input low unless interrupt enabled
    assign in_ok_w     = adis & (float_req ? eint_en : '1);

    // Registered pad controls, so outputs come from flops
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pin_out       <= '0;
            pin_oe_n      <= '1;
            pin_pullup_en <= '0;
            pin_level     <= '0;
        end else begin
            pin_out       <= latch;
            pin_oe_n      <= ~drive_w;
            pin_pullup_en <= pull_sel & ~drive_low_w;
            pin_level     <= pin_in & in_ok_w;
        end
    end

endmodule // port_pad_ctrl
